// >>> rtl/msd_pkg.sv
// How it works
// - three modes: current monitor, contact-assisted monitor, contactor control
// - current monitor: average current at start threshold enters starting
// - contact mode: contact closing or current at threshold enters starting
// - timer detection: run on timer expiry or current overshoot then drop
// - current detection: run timer ignored, current alone decides running
// - current monitor: current below off threshold declares off
// - contact mode: off needs contact open and current below off threshold
// - control stop: de-energise contactor, trip if contact stays closed 1 s
// - protection trip while starting or running enters trip state
// - trip entry lights panel indication and stores cause in snapshot
// - trip state held until explicit trip reset
// - monitor modes may keep watching breaker while tripped
package msd_pkg;
   localparam logic [1:0] MODE_CURRENT = 2'h0;
   localparam logic [1:0] MODE_CONTACT = 2'h1;
   localparam logic [1:0] MODE_CONTROL = 2'h2;
   // register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_START_TH = 6'h04;
   localparam logic [5:0] OFS_RUN_TH = 6'h08;
   localparam logic [5:0] OFS_OFF_TH = 6'h0C;
   localparam logic [5:0] OFS_RUN_TIME = 6'h10;
   localparam logic [5:0] OFS_STATUS = 6'h14;
   localparam logic [5:0] OFS_IRQ_STAT = 6'h18;
   localparam logic [5:0] OFS_IRQ_EN = 6'h1C;
   localparam logic [5:0] OFS_IRQ_CLR = 6'h20;
   localparam logic [5:0] OFS_CMD = 6'h24;
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RUNDET_BIT = 2;
   localparam int CTRL_VERIFY_BIT = 3;
   // command register bits (write 1 to act)
   localparam int CMD_START_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int CMD_TRIP_RST_BIT = 2;
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [15:0] START_TH_RST = 16'h0100;
   localparam logic [15:0] RUN_TH_RST = 16'h0080;
   localparam logic [15:0] OFF_TH_RST = 16'h0010;
   localparam logic [15:0] RUN_TIME_RST = 16'h000A;
   // run overshoot margin: 10 percent, as numerator over 10
   localparam logic [3:0] RUN_MARGIN_NUM = 4'hB;
   // timing: 1 ms tick at 200 MHz, stuck timeout 1 s
   localparam int CLK_MHZ = 200;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_MHZ * TICK_US;
   localparam int STUCK_MS = 1000;
   localparam int IRQ_N = 4;
   localparam int IRQ_START = 0;
   localparam int IRQ_RUN = 1;
   localparam int IRQ_OFF = 2;
   localparam int IRQ_TRIP = 3;
   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_SPINUP = 5'h02,
      ST_RUN = 5'h04,
      ST_STOPPING = 5'h08,
      ST_TRIP = 5'h10
   } msd_state_t;
   // trip causes in the snapshot
   localparam logic [1:0] CAUSE_NONE = 2'h0;
   localparam logic [1:0] CAUSE_PROT = 2'h1;
   localparam logic [1:0] CAUSE_STUCK = 2'h2;
endpackage

// >>> rtl/msd_tick.sv
`timescale 1ns/10ps
// one-cycle millisecond enable pulse
module msd_tick
   import msd_pkg::*;
   #(parameter int DIV = TICK_CYC) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // synchronised reset
   output logic tick // 1 ms enable pulse
);
   logic [17:0] cnt_r;
   wire wrap = (cnt_r == 18'(DIV - 1));
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 18'h00000;
         tick <= 1'b0;
      end else begin
         cnt_r <= wrap ? 18'h00000 : cnt_r + 18'h00001;
         tick <= wrap;
      end
   end
endmodule

// >>> rtl/msd_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module msd_top
   import msd_pkg::*;
   #(parameter int TICK_DIV = TICK_CYC) (
   input wire logic clk_sys, // 200 MHz clock
   input wire logic resetn, // async reset, low active
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // response valid
   input wire logic s_axi_bready, // response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read valid
   input wire logic s_axi_rready, // read ready
   input wire logic [15:0] avg_current, // averaged current, same clock
   input wire logic prot_trip, // protection trip request, same clock
   input wire logic breaker_aux_contact, // aux contact pin, high closed
   output logic contactor_out, // contactor drive, high energised
   output logic trip_led, // front panel trip indication
   output logic irq // level interrupt
);
   ////////////////////////////////////////////////////////////////
   // reset release and pin synchroniser
   logic rst_s1_r, rst_n_r, aux_s1_r, aux_r;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aux_s1_r <= 1'b0;
         aux_r <= 1'b0;
      end else begin
         aux_s1_r <= breaker_aux_contact;
         aux_r <= aux_s1_r;
      end
   end
   logic tick;
   msd_tick #(.DIV(TICK_DIV)) u_tick (
      .clk_sys(clk_sys),
      .rst_n(rst_n_r),
      .tick(tick)
   );
   ////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data taken in either order
   logic aw_hold_r, w_hold_r;
   logic [5:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] ctrl_r;
   logic [15:0] start_th_r, run_th_r, off_th_r, run_time_r;
   logic [IRQ_N-1:0] irq_stat_r, irq_en_r, irq_ev;
   logic [1:0] cause_r;
   msd_state_t st_r, st_nxt;
   wire do_wr = aw_hold_r && w_hold_r && !s_axi_bvalid;
   wire aw_ok = aw_addr_r[5:2] <= OFS_CMD[5:2];
   wire wr_ctrl = do_wr && aw_addr_r == OFS_CTRL;
   wire wr_irq_en = do_wr && aw_addr_r == OFS_IRQ_EN;
   wire wr_irq_clr = do_wr && aw_addr_r == OFS_IRQ_CLR;
   wire wr_cmd = do_wr && aw_addr_r == OFS_CMD;
   wire cmd_start = wr_cmd && w_data_r[CMD_START_BIT];
   wire cmd_stop = wr_cmd && w_data_r[CMD_STOP_BIT];
   wire cmd_trip_rst = wr_cmd && w_data_r[CMD_TRIP_RST_BIT];
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 6'h00;
         w_data_r <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr[5:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_ok && aw_addr_r[1:0] == 2'h0 ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   // writable registers; bytes 0-1 only carry data
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r <= CTRL_RST;
         start_th_r <= START_TH_RST;
         run_th_r <= RUN_TH_RST;
         off_th_r <= OFF_TH_RST;
         run_time_r <= RUN_TIME_RST;
         irq_en_r <= '0;
      end else if (do_wr) begin
         if (wr_ctrl) ctrl_r <= w_data_r[3:0];
         if (aw_addr_r == OFS_START_TH) start_th_r <= w_data_r[15:0];
         if (aw_addr_r == OFS_RUN_TH) run_th_r <= w_data_r[15:0];
         if (aw_addr_r == OFS_OFF_TH) off_th_r <= w_data_r[15:0];
         if (aw_addr_r == OFS_RUN_TIME) run_time_r <= w_data_r[15:0];
         if (wr_irq_en) irq_en_r <= w_data_r[IRQ_N-1:0];
      end
   end
   // read mux
   wire [5:0] ra = s_axi_araddr[5:0];
   wire [31:0] rd_mux =
      ra == OFS_CTRL ? {28'h0000000, ctrl_r} :
      ra == OFS_START_TH ? {16'h0000, start_th_r} :
      ra == OFS_RUN_TH ? {16'h0000, run_th_r} :
      ra == OFS_OFF_TH ? {16'h0000, off_th_r} :
      ra == OFS_RUN_TIME ? {16'h0000, run_time_r} :
      ra == OFS_STATUS ? {23'h000000, aux_r, contactor_out, cause_r,
                          st_r} :
      ra == OFS_IRQ_STAT ? {28'h0000000, irq_stat_r} :
      ra == OFS_IRQ_EN ? {28'h0000000, irq_en_r} : 32'h00000000;
   wire rd_ok = ra[5:2] <= OFS_CMD[5:2] && ra[1:0] == 2'h0;
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = !s_axi_rvalid;
   ////////////////////////////////////////////////////////////////
   // motor state detection
   wire [1:0] mode = ctrl_r[CTRL_MODE_LSB +: 2];
   wire run_by_current = ctrl_r[CTRL_RUNDET_BIT];
   wire verify = ctrl_r[CTRL_VERIFY_BIT];
   wire is_ctl = mode == MODE_CONTROL;
   wire [19:0] margin = 20'(run_th_r) * 20'(RUN_MARGIN_NUM);
   wire [19:0] cur10 = 20'(avg_current) * 20'd10;
   wire over_margin = cur10 > margin;
   wire cur_start = avg_current >= start_th_r;
   wire cur_off = avg_current < off_th_r;
   wire cur_below_run = avg_current < run_th_r;
   logic over_seen_r, aux_was_r;
   logic [15:0] ms_cnt_r;
   // start condition per mode
   wire start_cond =
      is_ctl ? cmd_start :
      mode == MODE_CONTACT ? (aux_r && !aux_was_r) || cur_start :
      cur_start;
   // run condition: timer or overshoot-then-drop
   wire run_drop = over_seen_r && cur_below_run;
   wire run_cond = run_by_current ? run_drop :
      run_drop || (tick && ms_cnt_r >= run_time_r);
   // off condition in the monitor modes
   wire off_cond = mode == MODE_CONTACT ? !aux_r && cur_off : cur_off;
   wire stuck = st_r == ST_STOPPING && tick && aux_r &&
      ms_cnt_r >= 16'(STUCK_MS - 1);
   wire in_motion = st_r == ST_SPINUP || st_r == ST_RUN;
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_OFF: if (start_cond) st_nxt = ST_SPINUP;
         ST_SPINUP: begin
            if (prot_trip) st_nxt = ST_TRIP;
            else if (is_ctl && cmd_stop) st_nxt = ST_STOPPING;
            else if (!is_ctl && off_cond) st_nxt = ST_OFF;
            else if (run_cond) st_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (prot_trip) st_nxt = ST_TRIP;
            else if (is_ctl && cmd_stop) st_nxt = ST_STOPPING;
            else if (!is_ctl && off_cond) st_nxt = ST_OFF;
         end
         ST_STOPPING: begin
            if (stuck) st_nxt = ST_TRIP;
            else if (!aux_r) st_nxt = ST_OFF;
         end
         ST_TRIP: if (cmd_trip_rst) st_nxt = ST_OFF;
         default: st_nxt = ST_OFF;
      endcase
   end
   // state, timers, contactor and snapshot
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= ST_OFF;
         contactor_out <= 1'b0;
         trip_led <= 1'b0;
         cause_r <= CAUSE_NONE;
         over_seen_r <= 1'b0;
         aux_was_r <= 1'b0;
         ms_cnt_r <= 16'h0000;
      end else begin
         st_r <= st_nxt;
         aux_was_r <= aux_r;
         if (st_nxt != st_r) ms_cnt_r <= 16'h0000;
         else if (tick && ms_cnt_r != 16'hFFFF) ms_cnt_r <= ms_cnt_r + 16'h0001;
         if (st_r != ST_SPINUP) over_seen_r <= 1'b0;
         else if (over_margin) over_seen_r <= 1'b1;
         // contactor only driven in control mode; trip drops it
         contactor_out <= is_ctl && (st_nxt == ST_SPINUP || st_nxt == ST_RUN);
         trip_led <= st_nxt == ST_TRIP;
         if (st_r != ST_TRIP && st_nxt == ST_TRIP)
            cause_r <= stuck ? CAUSE_STUCK : CAUSE_PROT;
         else if (st_r == ST_TRIP && st_nxt == ST_OFF)
            cause_r <= CAUSE_NONE;
      end
   end
   // breaker mismatch while tripped: closed contact or current still
   // flowing is flagged but never leaves trip on its own
   wire trip_watch = st_r == ST_TRIP && !is_ctl && verify &&
      (aux_r || !cur_off);
   ////////////////////////////////////////////////////////////////
   // interrupts: set beats clear
   assign irq_ev[IRQ_START] = st_r != ST_SPINUP && st_nxt == ST_SPINUP;
   assign irq_ev[IRQ_RUN] = st_r != ST_RUN && st_nxt == ST_RUN;
   assign irq_ev[IRQ_OFF] = st_r != ST_OFF && st_nxt == ST_OFF;
   assign irq_ev[IRQ_TRIP] = (st_r != ST_TRIP && st_nxt == ST_TRIP) ||
      trip_watch;
   wire [IRQ_N-1:0] clr = wr_irq_clr ? w_data_r[IRQ_N-1:0] : '0;
   always_ff @(posedge clk_sys or negedge rst_n_r) begin
      if (!rst_n_r) begin
         irq_stat_r <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~clr) | irq_ev;
         irq <= |(((irq_stat_r & ~clr) | irq_ev) & irq_en_r);
      end
   end
   ////////////////////////////////////////////////////////////////
   // checks
   a_trip_entry: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
      in_motion && prot_trip |=> st_r == ST_TRIP ##0 trip_led)
      else $error("protection trip not taken");
   a_trip_hold: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
      st_r == ST_TRIP && !cmd_trip_rst |=> st_r == ST_TRIP)
      else $error("trip left without reset");
   a_ctl_start: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
      st_r == ST_OFF && is_ctl && cmd_start |=>
      st_r == ST_SPINUP && contactor_out)
      else $error("start command ignored");
   a_stop_deenergise: assert property (@(posedge clk_sys)
      disable iff (!rst_n_r)
      st_r == ST_STOPPING |-> !contactor_out)
      else $error("contactor on while stopping");
   a_cause_stored: assert property (@(posedge clk_sys)
      disable iff (!rst_n_r)
      $rose(st_r == ST_TRIP) |-> cause_r != CAUSE_NONE)
      else $error("trip cause missing");
   a_cur_start: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
      st_r == ST_OFF && mode == MODE_CURRENT && cur_start |=>
      st_r == ST_SPINUP)
      else $error("current start missed");
   a_contact_off: assert property (@(posedge clk_sys)
      disable iff (!rst_n_r)
      st_r == ST_RUN && mode == MODE_CONTACT && aux_r && !prot_trip |=>
      st_r == ST_RUN)
      else $error("off with contact closed");
   a_cur_off: assert property (@(posedge clk_sys) disable iff (!rst_n_r)
      st_r == ST_RUN && mode == MODE_CURRENT && cur_off && !prot_trip |=>
      st_r == ST_OFF)
      else $error("current off missed");
   c_run: cover property (@(posedge clk_sys) st_r == ST_RUN);
   c_stuck: cover property (@(posedge clk_sys) stuck);
   c_trip_rst: cover property (@(posedge clk_sys)
      st_r == ST_TRIP && cmd_trip_rst);
endmodule

// >>> test/msd_motor_model.sv
`timescale 1ns/10ps
// contactor, breaker aux contact and current sensing beside the block
module msd_motor_model (
   input wire logic clk_sys, // system clock
   input wire logic contactor_out, // contactor drive
   input wire logic hand_close, // breaker closed by hand
   input wire logic stuck, // welded contactor
   input wire logic slow, // slow armature
   input wire logic [15:0] cur_set, // current at the sensor
   output logic breaker_aux_contact, // aux contact, high closed
   output logic [15:0] avg_current // averaged current
);
   logic aux_r = 1'b0;
   int cnt_r = 0;
   // armature follows the drive only after its travel time
   always_ff @(posedge clk_sys) begin
      if (aux_r == contactor_out) begin
         cnt_r <= 0;
      end else if (cnt_r >= (slow ? 40 : 3)) begin
         aux_r <= contactor_out;
         cnt_r <= 0;
      end else begin
         cnt_r <= cnt_r + 1;
      end
   end
   // a welded contact stays closed whatever the drive does
   assign breaker_aux_contact = aux_r | stuck | hand_close;
   assign avg_current = cur_set;
endmodule

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
   import msd_pkg::*;
   logic clk_sys, resetn, prot_trip, hand_close, stuck, slow;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, contactor_out, trip_led, irq, aux;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [15:0] cur_set, avg_current;
   int n_mismatch = 0;
   int samples_checked = 0;
   msd_top #(.TICK_DIV(10)) msd_top_i (.clk_sys(clk_sys), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .avg_current(avg_current),
      .prot_trip(prot_trip), .breaker_aux_contact(aux),
      .contactor_out(contactor_out), .trip_led(trip_led), .irq(irq));
   msd_motor_model msd_motor_model_i (.clk_sys(clk_sys),
      .contactor_out(contactor_out), .hand_close(hand_close),
      .stuck(stuck), .slow(slow), .cur_set(cur_set),
      .breaker_aux_contact(aux), .avg_current(avg_current));
   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog; a hang is far beyond the expected run length
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #400000;
      n_mismatch++;
      final_report();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // bus tasks: address and data offered together, response awaited
   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= {26'h0, a};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 200);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 200) n_mismatch++;
   endtask
   task automatic rd(input logic [5:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= {26'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 200);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 200) n_mismatch++;
   endtask
   // polls status low byte under a mask, at most lim reads
   task automatic st(input logic [7:0] m, input logic [7:0] e, input int lim);
      int n;
      n = 0;
      do begin
         rd(OFS_STATUS);
         n++;
      end while ((d[7:0] & m) !== e && n < lim);
      chk({24'h0, d[7:0] & m}, {24'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      st(8'hFF, {3'h0, ST_OFF}, 1);
      chk({29'h0, contactor_out, trip_led, irq}, 32'h0);
      rd(OFS_START_TH);
      chk(d, {16'h0, START_TH_RST});
      wr(6'h3C, 32'h1);
      chk({30'h0, r}, 32'h2);
      rd(6'h3C);
      chk({d[29:0], r}, 32'h2);
   endtask
   task automatic t_current();
      wr(OFS_IRQ_EN, 32'h0);
      @(posedge clk_sys) cur_set <= 16'h0100;
      st(8'h1F, {3'h0, ST_SPINUP}, 50);
      rd(OFS_IRQ_STAT);
      chk({d[31:1], irq}, 32'h0);
      chk(d & 32'h1, 32'h1);
      wr(OFS_IRQ_EN, 32'h1 << IRQ_START);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQ_CLR, 32'hF);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      st(8'h1F, {3'h0, ST_RUN}, 100);
      @(posedge clk_sys) cur_set <= 16'h0008;
      st(8'h1F, {3'h0, ST_OFF}, 50);
   endtask
   task automatic t_contact();
      wr(OFS_CTRL, 32'(MODE_CONTACT) | (32'h1 << CTRL_RUNDET_BIT));
      @(posedge clk_sys) hand_close <= 1'b1;
      st(8'h1F, {3'h0, ST_SPINUP}, 50);
      repeat (300) @(posedge clk_sys);
      st(8'h1F, {3'h0, ST_SPINUP}, 1);
      @(posedge clk_sys) cur_set <= 16'h0090;
      repeat (20) @(posedge clk_sys);
      cur_set <= 16'h0070;
      st(8'h1F, {3'h0, ST_RUN}, 50);
      @(posedge clk_sys) cur_set <= 16'h0005;
      repeat (50) @(posedge clk_sys);
      st(8'h1F, {3'h0, ST_RUN}, 1);
      hand_close <= 1'b0;
      st(8'h1F, {3'h0, ST_OFF}, 50);
   endtask
   // breaker check while tripped: a closed contact keeps flagging the trip
   task automatic t_watch();
      wr(OFS_CTRL, 32'(MODE_CONTACT) | (32'h1 << CTRL_VERIFY_BIT));
      wr(OFS_IRQ_EN, 32'h1 << IRQ_TRIP);
      @(posedge clk_sys) hand_close <= 1'b1;
      st(8'h1F, {3'h0, ST_SPINUP}, 50);
      @(posedge clk_sys) prot_trip <= 1'b1;
      @(posedge clk_sys) prot_trip <= 1'b0;
      st(8'h7F, {1'b0, CAUSE_PROT, ST_TRIP}, 4);
      wr(OFS_IRQ_CLR, 32'hF);
      rd(OFS_IRQ_STAT);
      chk(d & 32'h8, 32'h8);
      hand_close <= 1'b0;
      repeat (5) @(posedge clk_sys);
      wr(OFS_IRQ_CLR, 32'hF);
      rd(OFS_IRQ_STAT);
      chk(d & 32'h8, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_CMD, 32'h1 << CMD_TRIP_RST_BIT);
      st(8'h7F, {3'h0, ST_OFF}, 4);
   endtask
   task automatic t_control();
      wr(OFS_CTRL, 32'(MODE_CONTROL));
      wr(OFS_CMD, 32'h1 << CMD_START_BIT);
      st(8'h9F, {3'h4, ST_SPINUP}, 2);
      @(posedge clk_sys) prot_trip <= 1'b1;
      @(posedge clk_sys) prot_trip <= 1'b0;
      st(8'h7F, {1'b0, CAUSE_PROT, ST_TRIP}, 4);
      chk({31'h0, trip_led}, 32'h1);
      repeat (100) @(posedge clk_sys);
      st(8'h7F, {1'b0, CAUSE_PROT, ST_TRIP}, 1);
      wr(OFS_CMD, 32'h1 << CMD_TRIP_RST_BIT);
      st(8'h7F, {1'b0, CAUSE_NONE, ST_OFF}, 4);
      chk({31'h0, trip_led}, 32'h0);
   endtask
   // slow but healthy contactor first, then a welded one
   task automatic t_stop();
      slow <= 1'b1;
      wr(OFS_CMD, 32'h1 << CMD_START_BIT);
      st(8'h9F, {3'h4, ST_RUN}, 100);
      wr(OFS_CMD, 32'h1 << CMD_STOP_BIT);
      st(8'hFF, {3'h0, ST_STOPPING}, 2);
      chk({31'h0, contactor_out}, 32'h0);
      st(8'h1F, {3'h0, ST_OFF}, 100);
      wr(OFS_CMD, 32'h1 << CMD_START_BIT);
      st(8'h1F, {3'h0, ST_RUN}, 100);
      stuck <= 1'b1;
      wr(OFS_CMD, 32'h1 << CMD_STOP_BIT);
      repeat (9000) @(posedge clk_sys);
      st(8'hFF, {3'h0, ST_STOPPING}, 1);
      st(8'h7F, {1'b0, CAUSE_STUCK, ST_TRIP}, 1000);
      stuck <= 1'b0;
      wr(OFS_CMD, 32'h1 << CMD_TRIP_RST_BIT);
      st(8'h7F, {3'h0, ST_OFF}, 50);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, prot_trip} = 3'h0;
      {hand_close, stuck, slow} = 3'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      cur_set = 16'h0000;
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_current();
      t_contact();
      t_watch();
      t_control();
      t_stop();
      final_report();
   end
endmodule
